// >>> adc_timing_pkg.sv
// constants, types and helpers shared by the converter timing control
package adc_timing_pkg;

  // ****************************************
  // result codes
  // ****************************************
  localparam int             RES_W     = 10;
  localparam logic [RES_W-1:0] CODE_ZERO = 10'h000;
  localparam logic [RES_W-1:0] CODE_FULL = 10'h3ff;
  localparam logic [RES_W-1:0] CODE_MSB  = 10'h200;

  // ****************************************
  // converter_control_register field layout
  // ****************************************
  localparam int CTRL_W     = 16;
  localparam int CC_SEL_LO  = 14;
  localparam int SC_SEL_LO  = 12;

  // conversion_clock_select codes and periods in basic_time_unit
  localparam logic [1:0]  CC_SEL_24   = 2'h0;
  localparam logic [1:0]  CC_SEL_RSVD = 2'h1;
  localparam logic [1:0]  CC_SEL_96   = 2'h2;
  localparam logic [1:0]  CC_SEL_48   = 2'h3;
  localparam int          UNIT_W      = 12;
  localparam logic [UNIT_W-1:0] CC_UNITS_24 = 12'h018;
  localparam logic [UNIT_W-1:0] CC_UNITS_96 = 12'h060;
  localparam logic [UNIT_W-1:0] CC_UNITS_48 = 12'h030;

  // ****************************************
  // sequence lengths
  // ****************************************
  localparam int          SAR_BITS       = 10;
  localparam int          CONV_PERIODS   = 14;
  localparam int          SAMPLE_PERIODS = 2;
  localparam int          CAL_PERIODS    = 4;
  localparam logic [UNIT_W-1:0] LOAD_UNITS = 12'h004;
  localparam int          PER_W          = 4;
  localparam int          CNT_W          = 16;
  localparam int          TCL_MAX        = 16;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_SAMPLE  = 5'h02,
    ST_CONVERT = 5'h04,
    ST_LOAD    = 5'h08,
    ST_CAL     = 5'h10
  } state_t;

  typedef struct packed {
    logic cmp_hi;
    logic above_ref;
    logic below_gnd;
  } front_t;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [UNIT_W-1:0] tcc_units(input logic [1:0] sel);
    unique case (sel)
      CC_SEL_96: tcc_units = CC_UNITS_96;
      CC_SEL_48: tcc_units = CC_UNITS_48;
      default:   tcc_units = CC_UNITS_24;
    endcase
  endfunction

  function automatic logic [UNIT_W-1:0] tsc_units(input logic [1:0] cc,
                                                  input logic [1:0] sc);
    tsc_units = tcc_units(cc) << sc;
  endfunction

endpackage

// >>> period_timer.sv
// interval timer counting basic time units on the cpu clock
`timescale 1ns/1ns
module period_timer
  import adc_timing_pkg::*;
#(
  parameter int TCL_CYCLES = 1
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // control
  input  wire logic              load_i,
  input  wire logic [UNIT_W-1:0] units_i,
  output logic                   tick_o
);

  if (TCL_CYCLES < 1 || TCL_CYCLES > TCL_MAX) begin : g_bad_tcl
    $error("TCL_CYCLES out of range");
  end

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = CNT_W'(units_i) * CNT_W'(TCL_CYCLES);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick_o = (cnt_r == CNT_W'(1));

endmodule // period_timer

// >>> adc_timing_control.sv
// sample and conversion sequencer of the 10-bit converter
`timescale 1ns/1ns

module adc_timing_control
  import adc_timing_pkg::*;
#(
  parameter int TCL_CYCLES = 1
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // cpu side
  input  wire logic [CTRL_W-1:0] ctrl_i,
  input  wire logic              start_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic [RES_W-1:0]       result_o,
  // analog front end
  input  wire front_t            front_i,
  output logic                   track_o,
  output logic                   cal_o,
  output logic [RES_W-1:0]       trial_o
);

  if (TCL_CYCLES < 1 || TCL_CYCLES > TCL_MAX) begin : g_bad_tcl
    $error("TCL_CYCLES out of range");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  front_t s1_r, s2_r, s3_r, flt_r;
  front_t flt_nxt;

  always_comb begin
    flt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      flt_r <= '0;
    end else begin
      s1_r  <= front_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  state_t             state_r, state_nxt;
  logic [1:0]         cc_r, cc_nxt;
  logic [1:0]         sc_r, sc_nxt;
  logic [PER_W-1:0]   per_r, per_nxt;
  logic [RES_W-1:0]   sar_r, sar_nxt;
  logic [RES_W-1:0]   bit_r, bit_nxt;
  logic               over_r, over_nxt;
  logic               under_r, under_nxt;
  logic [RES_W-1:0]   result_r, result_nxt;
  logic               done_r, done_nxt;
  logic               busy_r, track_r, cal_r;
  logic               tmr_load;
  logic [UNIT_W-1:0]  tmr_units;
  logic               tick;
  logic [1:0]         cc_new, sc_new;
  logic [UNIT_W-1:0]  tcc;

  period_timer #(
    .TCL_CYCLES (TCL_CYCLES)
  ) u_timer (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .load_i  (tmr_load),
    .units_i (tmr_units),
    .tick_o  (tick)
  );

  always_comb begin
    state_nxt  = state_r;
    cc_nxt     = cc_r;
    sc_nxt     = sc_r;
    per_nxt    = per_r;
    sar_nxt    = sar_r;
    bit_nxt    = bit_r;
    over_nxt   = over_r;
    under_nxt  = under_r;
    result_nxt = result_r;
    done_nxt   = 1'b0;
    tmr_load   = 1'b0;
    tmr_units  = '0;
    cc_new     = ctrl_i[CC_SEL_LO +: 2];
    sc_new     = ctrl_i[SC_SEL_LO +: 2];
    tcc        = tcc_units(cc_r);
    unique case (state_r)
      ST_IDLE: begin
        if (start_i) begin
          cc_nxt    = cc_new;
          sc_nxt    = sc_new;
          state_nxt = ST_SAMPLE;
          tmr_load  = 1'b1;
          tmr_units = UNIT_W'(SAMPLE_PERIODS) * tsc_units(cc_new, sc_new);
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          over_nxt  = flt_r.above_ref;
          under_nxt = flt_r.below_gnd;
          state_nxt = ST_CONVERT;
          tmr_load  = 1'b1;
          tmr_units = tcc;
          sar_nxt   = CODE_MSB;
          bit_nxt   = CODE_MSB;
          per_nxt   = '0;
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          if (per_r < PER_W'(SAR_BITS)) begin
            sar_nxt = (flt_r.cmp_hi ? sar_r : (sar_r & ~bit_r)) | (bit_r >> 1);
            bit_nxt = bit_r >> 1;
          end
          per_nxt  = per_r + PER_W'(1);
          tmr_load = 1'b1;
          if (per_r == PER_W'(CONV_PERIODS - 1)) begin
            state_nxt = ST_LOAD;
            tmr_units = LOAD_UNITS;
          end else begin
            tmr_units = tcc;
          end
        end
      end
      ST_LOAD: begin
        if (tick) begin
          result_nxt = over_r ? CODE_FULL : (under_r ? CODE_ZERO : sar_r);
          done_nxt   = 1'b1;
          state_nxt  = ST_CAL;
          tmr_load   = 1'b1;
          tmr_units  = tcc;
          per_nxt    = '0;
        end
      end
      ST_CAL: begin
        if (tick) begin
          per_nxt = per_r + PER_W'(1);
          if (per_r == PER_W'(CAL_PERIODS - 1)) begin
            state_nxt = ST_IDLE;
          end else begin
            tmr_load  = 1'b1;
            tmr_units = tcc;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r  <= ST_IDLE;
      cc_r     <= CC_SEL_24;
      sc_r     <= 2'h0;
      per_r    <= '0;
      sar_r    <= CODE_ZERO;
      bit_r    <= CODE_ZERO;
      over_r   <= 1'b0;
      under_r  <= 1'b0;
      result_r <= CODE_ZERO;
      done_r   <= 1'b0;
      busy_r   <= 1'b0;
      track_r  <= 1'b0;
      cal_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cc_r     <= cc_nxt;
      sc_r     <= sc_nxt;
      per_r    <= per_nxt;
      sar_r    <= sar_nxt;
      bit_r    <= bit_nxt;
      over_r   <= over_nxt;
      under_r  <= under_nxt;
      result_r <= result_nxt;
      done_r   <= done_nxt;
      busy_r   <= (state_nxt != ST_IDLE);
      track_r  <= (state_nxt == ST_SAMPLE);
      cal_r    <= (state_nxt == ST_CAL);
    end
  end

  assign busy_o   = busy_r;
  assign done_o   = done_r;
  assign result_o = result_r;
  assign track_o  = track_r;
  assign cal_o    = cal_r;
  assign trial_o  = sar_r;

  // ****************************************
  // checks
  // ****************************************
  logic [CNT_W-1:0] elapsed_r, phase_r;
  int               tcc_cyc, tsc_cyc;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      elapsed_r <= '0;
      phase_r   <= '0;
    end else begin
      elapsed_r <= (state_r == ST_IDLE) ? '0 : elapsed_r + CNT_W'(1);
      phase_r   <= (state_nxt != state_r) ? CNT_W'(1) : phase_r + CNT_W'(1);
    end
  end

  assign tcc_cyc = int'(tcc) * TCL_CYCLES;
  assign tsc_cyc = int'(tsc_units(cc_r, sc_r)) * TCL_CYCLES;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  AST_CONV_PHASE: assert property (
    (state_r == ST_CONVERT && state_nxt == ST_LOAD) |-> int'(phase_r) == CONV_PERIODS * tcc_cyc)
    else $error("conversion phase length wrong");
  AST_SAMPLE_PHASE: assert property (
    (state_r == ST_SAMPLE && state_nxt != ST_SAMPLE) |->
      int'(phase_r) == SAMPLE_PERIODS * tsc_cyc)
    else $error("sample phase length wrong");
  AST_CLAMP_HIGH: assert property (
    $rose(done_o) && over_r |-> result_o == CODE_FULL)
    else $error("over-range result not full scale");
  AST_CLAMP_LOW: assert property (
    $rose(done_o) && under_r && !over_r |-> result_o == CODE_ZERO)
    else $error("under-range result not zero");
  AST_HOLD: assert property (
    (state_r == ST_CONVERT || state_r == ST_LOAD) |->
      !track_o ##1 $stable(over_r) && $stable(under_r))
    else $error("held level changed after sampling");
  AST_ORDER: assert property (
    (state_r == ST_SAMPLE && state_nxt != ST_SAMPLE) |=> state_r == ST_CONVERT)
    else $error("sample phase not followed by conversion");
  AST_ORDER_LOAD: assert property (
    (state_r == ST_CONVERT && state_nxt != ST_CONVERT) |=> state_r == ST_LOAD)
    else $error("conversion not followed by result load");
  AST_LOAD_CAL: assert property (
    (state_r == ST_LOAD && state_nxt != ST_LOAD) |=> state_r == ST_CAL && done_o && cal_o)
    else $error("result load not followed by calibration");
  AST_TOTAL: assert property (
    $rose(done_o) |-> int'(elapsed_r) ==
      CONV_PERIODS * tcc_cyc + SAMPLE_PERIODS * tsc_cyc + int'(LOAD_UNITS) * TCL_CYCLES)
    else $error("total conversion time wrong");
  AST_CAL: assert property (
    (state_r == ST_CAL && state_nxt == ST_IDLE) |-> int'(phase_r) == CAL_PERIODS * tcc_cyc
      && cal_o ##1 !cal_o && !busy_o)
    else $error("calibration length wrong");
  AST_LATCH: assert property (
    busy_o && state_r != ST_IDLE |=> $stable(cc_r) && $stable(sc_r))
    else $error("clock selects changed mid conversion");

  COV_DONE_96: cover property ($rose(done_o) && cc_r == CC_SEL_96);
  COV_DONE_48: cover property ($rose(done_o) && cc_r == CC_SEL_48 && sc_r == 2'h3);
  COV_CLAMP:   cover property ($rose(done_o) && over_r);
  COV_CAL_END: cover property (cal_o ##1 !busy_o);

endmodule // adc_timing_control

// >>> analog_front_model.sv
// behavioural sample-and-hold and comparator of the analog front end
`timescale 1ns/1ns
module analog_front_model
  import adc_timing_pkg::*;
(
  // clock
  input  wire logic               mclk_i,
  // analog pin
  input  wire logic signed [15:0] vin_i,
  // converter side
  input  wire logic               track_i,
  input  wire logic [RES_W-1:0]   trial_i,
  output front_t                  front_o
);
  // ****************************************
  // hold capacitor
  // ****************************************
  logic signed [15:0] held_r = 16'sh0000;

  always @(posedge mclk_i) begin
    if (track_i === 1'b1) begin
      held_r <= vin_i;
    end
  end

  // ****************************************
  // comparator and range detect
  // ****************************************
  assign front_o = '{cmp_hi:    held_r >= $signed({6'h00, trial_i}),
                     above_ref: held_r > 16'sh03ff,
                     below_gnd: held_r < 16'sh0000};
endmodule // analog_front_model

// >>> adc_timing_control_bench.sv
// self-checking bench of the converter timing control
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module adc_timing_control_bench;
  import adc_timing_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic               mclk_i;
  logic               rst_n_i;
  logic               start_i;
  logic               busy_o;
  logic               done_o;
  logic               track_o;
  logic               cal_o;
  logic [CTRL_W-1:0]  ctrl_i;
  logic [RES_W-1:0]   result_o;
  logic [RES_W-1:0]   trial_o;
  logic signed [15:0] vin;
  front_t             front_i;
  int                 n_fail;
  int                 tests_run;
  logic [1:0]         ccs [3] = '{CC_SEL_24, CC_SEL_96, CC_SEL_48};

  adc_timing_control #(.TCL_CYCLES(1)) adc_timing_control_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl_i), .start_i(start_i),
    .busy_o(busy_o), .done_o(done_o), .result_o(result_o), .front_i(front_i),
    .track_o(track_o), .cal_o(cal_o), .trial_o(trial_o));

  analog_front_model analog_front_model_inst (
    .mclk_i(mclk_i), .vin_i(vin), .track_i(track_o), .trial_i(trial_o),
    .front_o(front_i));

  // ****************************************
  // expectations
  // ****************************************
  function automatic int exp_tcc(input logic [1:0] cc);
    case (cc)
      2'h2:    return 96;
      2'h3:    return 48;
      default: return 24;
    endcase
  endfunction

  function automatic logic [RES_W-1:0] exp_code(input int v);
    if (v < 0) return 10'h000;
    if (v > 1023) return 10'h3ff;
    return 10'(v);
  endfunction

  // ****************************************
  // one conversion, busy requests thrown in
  // ****************************************
  task automatic run(input logic [1:0] cc, input logic [1:0] sc, input int v);
    int tcc = exp_tcc(cc);
    int tsc = tcc << sc;
    int t = 14 * tcc + 2 * tsc + 4;
    int nb = 0;
    int nt = 0;
    int nc = 0;
    int nd = 0;
    vin = 16'(v);
    ctrl_i = {cc, sc, 12'($urandom)};
    start_i = 1'b1;
    @(posedge mclk_i);
    #1;
    for (int k = 0; k < 5000 && busy_o === 1'b1; k++) begin
      nb++;
      nt += int'(track_o === 1'b1);
      nc += int'(cal_o === 1'b1);
      if (done_o === 1'b1) begin
        nd++;
        `CHK("done time", t, k)
        `CHK("result", exp_code(v), result_o)
      end
      if (k == 2 * tsc) `CHK("first trial", 10'h200, trial_o)
      if (k == 2 * tsc + 2) vin = 16'($urandom_range(0, 1023));
      if (k == 7) ctrl_i = {ccs[$urandom_range(0, 2)], 2'($urandom), 12'h000};
      start_i = (k < t + 4 * tcc - 1) ? 1'($urandom) : 1'b0;
      @(posedge mclk_i);
      #1;
    end
    `CHK("busy span", t + 4 * tcc, nb)
    `CHK("sample span", 2 * tsc, nt)
    `CHK("cal span", 4 * tcc, nc)
    `CHK("done count", 1, nd)
    `CHK("result held", exp_code(v), result_o)
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // clock, watchdog, sequence
  // ****************************************
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (100000) @(posedge mclk_i);
    n_fail++;
    wrap_up();
  end

  initial begin
    rst_n_i = 1'b0;
    start_i = 1'b0;
    ctrl_i = '0;
    vin = 16'sh0000;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(32'hcb28b6a6));
    repeat (10) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    `CHK("idle", 3'b000, {busy_o, done_o, track_o})
    run(CC_SEL_24, 2'h0, -5);
    run(CC_SEL_24, 2'h0, 0);
    run(CC_SEL_48, 2'h0, 1023);
    run(CC_SEL_24, 2'h1, 1500);
    foreach (ccs[i]) begin
      for (int s = 0; s < 4; s++) begin
        run(ccs[i], 2'(s), int'($urandom_range(0, 1400)) - 200);
      end
    end
    wrap_up();
  end
endmodule // adc_timing_control_bench
